// >>> hw/hub_pkg.sv
package hub_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_RATE = 9600;
    // A bit time rounds down to whole clock cycles (4166 at 40 MHz).
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int LED_PULSE_MS = 50;
    localparam int LED_PULSE_CYCLES = (CLK_HZ / 1000) * LED_PULSE_MS;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes and characters.
    localparam int NUM_DRIVES = 4;
    localparam int NUM_CHAN = NUM_DRIVES + 1;
    localparam int SEL_W = $clog2(NUM_DRIVES);
    localparam int CNT_W = 16;
    localparam int LED_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int CHAR_W = 8;
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_ADDR_BASE = 8'h31;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [3:0] RX_LAST_BIT = 4'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // States and carriers.
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;

    typedef enum logic [2:0] {
        ARB_IDLE = 3'h1,
        ARB_ADDR = 3'h2,
        ARB_BODY = 3'h4
    } arb_state_t;

    typedef enum logic {
        MODE_PROGRAM = 1'b0,
        MODE_ROUTER = 1'b1
    } power_mode_t;

    typedef struct packed {
        rx_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic done;
    } rx_t;

    typedef struct packed {
        logic busy;
        logic line;
        logic [CNT_W-1:0] cnt;
        logic [3:0] bitn;
        logic [9:0] sh;
    } tx_t;

    typedef struct packed {
        logic host;
        logic [NUM_DRIVES-1:0] drive;
    } serial_lines_t;

    typedef struct packed {
        logic valid;
        power_mode_t mode;
    } mode_set_t;

    typedef struct packed {
        rx_t [NUM_CHAN-1:0] rx;
        tx_t [NUM_CHAN-1:0] tx;
        arb_state_t arb;
        logic [SEL_W-1:0] sel;
        logic cmd_first;
        logic [NUM_DRIVES-1:0] cmd_mask;
        logic [NUM_DRIVES-1:0][3:0] cr_cnt;
        logic [LED_W-1:0] led_cnt;
        logic activity;
        logic power;
        power_mode_t mode;
        logic mode_loaded;
    } hub_state_t;

endpackage : hub_pkg

// >>> hw/char_fifo.sv
`timescale 1ns/1ps

module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count, so they never lie.
    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap explicitly, so a depth that is not a power of two also works.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

endmodule : char_fifo

// >>> hw/serial_command_router_hub.sv
`timescale 1ns/1ps

// Functional notes
// - Host and drive links use 9600 baud asynchronous framing, 8 data bits, one stop, no parity.
// - No flow-control lines exist; characters are taken and sent without any handshake.
// - Host commands are passed on to individual drive ports, of which there are four.
// - Commands end with carriage return 13 and a leading digit 1 to 4 picks the drive port.
// - A command without a leading address digit is broadcast to every drive port.
// - Each drive reply goes to the host with its port's address digit in front.
// - The activity indicator pulses for every command received from the host while routing; commands closer than the pulse share one flash.
// - The power indicator is lit while a powered drive sits on port 1.
// - A retained power-up mode selects router-only operation or stored-program operation.
module serial_command_router_hub #(
    parameter int BIT_TIME = hub_pkg::BIT_CYCLES,
    parameter int LED_TIME = hub_pkg::LED_PULSE_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire hub_pkg::serial_lines_t serial_in,
    output hub_pkg::serial_lines_t serial_out,
    input wire logic port1_powered,
    input wire hub_pkg::power_mode_t mode_retained,
    input wire hub_pkg::mode_set_t mode_set,
    output hub_pkg::power_mode_t power_up_mode,
    output logic router_active,
    output logic link_activity_indicator,
    output logic power_indicator
);
    import hub_pkg::*;

    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_TIME - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_TIME / 2 - 1);
    localparam logic [LED_W-1:0] LED_LAST = LED_W'(LED_TIME - 1);

    hub_state_t st;
    hub_state_t next_st;
    logic [NUM_CHAN-1:0] rx_line;
    logic drives_idle;
    logic cmd_in_valid;
    logic cmd_in_ready;
    logic cmd_out_valid;
    logic cmd_pop;
    logic cmd_is_addr;
    logic [7:0] cmd_out_data;
    logic [NUM_DRIVES-1:0] rep_in_valid;
    logic [NUM_DRIVES-1:0] rep_in_ready;
    logic [NUM_DRIVES-1:0] rep_out_valid;
    logic [NUM_DRIVES-1:0] rep_pop;
    logic [7:0] rep_out_data [NUM_DRIVES];
    logic pick_valid;
    logic [SEL_W-1:0] pick;

    // Starts a frame: start bit now, then data LSB first, then the stop bit.
    function automatic tx_t load_tx(input tx_t t, input logic [7:0] ch);
        tx_t r;
        r = t;
        r.busy = 1'b1;
        r.line = 1'b0;
        r.cnt = '0;
        r.bitn = '0;
        r.sh = {1'b1, ch, 1'b0};
        return r;
    endfunction : load_tx

    ////////////////////////////////////////////////////////////////////////////////
    // Pins and status outputs.

    // Channel 0 is the host, channels 1 to 4 are drive ports 1 to 4.
    assign rx_line = {serial_in.drive, serial_in.host};
    assign router_active = st.mode_loaded && (st.mode == MODE_ROUTER);
    assign power_up_mode = st.mode;
    assign link_activity_indicator = st.activity;
    assign power_indicator = st.power;

    // Serial lines come from the transmitter flip-flops; no RTS or CTS anywhere.
    always_comb begin
        serial_out.host = st.tx[0].line;
        for (int i = 0; i < NUM_DRIVES; i++) begin
            serial_out.drive[i] = st.tx[i+1].line;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffers: one for host commands, one per drive for replies.

    // A host character is kept only while routing; a full buffer drops it.
    assign cmd_in_valid = st.rx[0].done && router_active;

    char_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(cmd_in_valid),
        .in_ready(cmd_in_ready),
        .in_data(st.rx[0].sh),
        .out_valid(cmd_out_valid),
        .out_ready(cmd_pop),
        .out_data(cmd_out_data)
    );

    // Drives cannot be throttled, so a reply longer than the buffer loses characters.
    for (genvar p = 0; p < NUM_DRIVES; p++) begin : g_reply
        assign rep_in_valid[p] = st.rx[p+1].done && router_active;

        char_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_rep_fifo (
            .mclk(mclk),
            .nrst(nrst),
            .ce(ce),
            .in_valid(rep_in_valid[p]),
            .in_ready(rep_in_ready[p]),
            .in_data(st.rx[p+1].sh),
            .out_valid(rep_out_valid[p]),
            .out_ready(rep_pop[p]),
            .out_data(rep_out_data[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Handshakes between the buffers and the transmitters.

    // Commands drain only when every drive transmitter is free, which keeps a
    // broadcast character in step on all four ports at the cost of a little speed.
    always_comb begin
        drives_idle = 1'b1;
        for (int i = 1; i < NUM_CHAN; i++) begin
            drives_idle = drives_idle && !st.tx[i].busy;
        end
        cmd_is_addr = (cmd_out_data >= CHAR_ADDR_BASE)
                   && (cmd_out_data < CHAR_ADDR_BASE + 8'(NUM_DRIVES));
        cmd_pop = router_active && cmd_out_valid && drives_idle;
        rep_pop = '0;
        if (router_active && st.arb == ARB_BODY && !st.tx[0].busy) begin
            rep_pop[st.sel] = rep_out_valid[st.sel];
        end
        // A port is ready once it holds a whole reply or its buffer is full;
        // the lowest port number wins.
        pick_valid = 1'b0;
        pick = '0;
        for (int p = NUM_DRIVES - 1; p >= 0; p--) begin
            if (st.cr_cnt[p] != 4'h0 || !rep_in_ready[p]) begin
                pick_valid = 1'b1;
                pick = SEL_W'(p);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [NUM_DRIVES-1:0] send_mask;
        logic cr_in;
        logic cr_out;
        send_mask = '0;
        cr_in = 1'b0;
        cr_out = 1'b0;
        next_st = st;

        // Receivers sample each bit at its centre and drop frames with a bad stop bit.
        for (int c = 0; c < NUM_CHAN; c++) begin
            next_st.rx[c].done = 1'b0;
            unique case (st.rx[c].st)
                RX_IDLE: begin
                    if (!rx_line[c]) begin
                        next_st.rx[c].st = RX_START;
                        next_st.rx[c].cnt = '0;
                    end
                end
                RX_START: begin
                    if (st.rx[c].cnt == HALF_LAST) begin
                        next_st.rx[c].cnt = '0;
                        next_st.rx[c].bitn = '0;
                        next_st.rx[c].st = rx_line[c] ? RX_IDLE : RX_DATA;
                    end else begin
                        next_st.rx[c].cnt = st.rx[c].cnt + 1'b1;
                    end
                end
                RX_DATA: begin
                    if (st.rx[c].cnt == BIT_LAST) begin
                        next_st.rx[c].cnt = '0;
                        next_st.rx[c].sh = {rx_line[c], st.rx[c].sh[7:1]};
                        next_st.rx[c].bitn = st.rx[c].bitn + 1'b1;
                        if (st.rx[c].bitn == RX_LAST_BIT) begin
                            next_st.rx[c].st = RX_STOP;
                        end
                    end else begin
                        next_st.rx[c].cnt = st.rx[c].cnt + 1'b1;
                    end
                end
                RX_STOP: begin
                    if (st.rx[c].cnt == BIT_LAST) begin
                        next_st.rx[c].done = rx_line[c];
                        next_st.rx[c].st = RX_IDLE;
                    end else begin
                        next_st.rx[c].cnt = st.rx[c].cnt + 1'b1;
                    end
                end
                default: next_st.rx[c].st = RX_IDLE;
            endcase
        end

        // Transmitters shift out ten bits: start, eight data, one stop.
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (st.tx[c].busy) begin
                if (st.tx[c].cnt == BIT_LAST) begin
                    next_st.tx[c].cnt = '0;
                    next_st.tx[c].bitn = st.tx[c].bitn + 1'b1;
                    next_st.tx[c].sh = {1'b1, st.tx[c].sh[9:1]};
                    next_st.tx[c].line = st.tx[c].sh[1];
                    if (st.tx[c].bitn == TX_LAST_BIT) begin
                        next_st.tx[c].busy = 1'b0;
                        next_st.tx[c].line = 1'b1;
                    end
                end else begin
                    next_st.tx[c].cnt = st.tx[c].cnt + 1'b1;
                end
            end
        end

        // Command steering: a leading digit 1 to 4 is consumed and picks one port, any
        // other first character opens a broadcast; carriage return rearms.
        if (cmd_pop) begin
            if (st.cmd_first && cmd_is_addr) begin
                next_st.cmd_mask = '0;
                next_st.cmd_mask[SEL_W'(cmd_out_data - CHAR_ADDR_BASE)] = 1'b1;
                next_st.cmd_first = 1'b0;
            end else begin
                send_mask = st.cmd_first ? {NUM_DRIVES{1'b1}} : st.cmd_mask;
                next_st.cmd_mask = send_mask;
                next_st.cmd_first = (cmd_out_data == CHAR_CR);
                for (int i = 0; i < NUM_DRIVES; i++) begin
                    if (send_mask[i]) begin
                        next_st.tx[i+1] = load_tx(st.tx[i+1], cmd_out_data);
                    end
                end
            end
        end

        // Reply arbiter: tag, then the whole reply up to its carriage return.
        unique case (st.arb)
            ARB_IDLE: begin
                if (router_active && pick_valid && !st.tx[0].busy) begin
                    next_st.sel = pick;
                    next_st.arb = ARB_ADDR;
                end
            end
            ARB_ADDR: begin
                next_st.tx[0] = load_tx(st.tx[0], CHAR_ADDR_BASE + 8'(st.sel));
                next_st.arb = ARB_BODY;
            end
            ARB_BODY: begin
                if (rep_pop[st.sel]) begin
                    next_st.tx[0] = load_tx(st.tx[0], rep_out_data[st.sel]);
                    if (rep_out_data[st.sel] == CHAR_CR) begin
                        next_st.arb = ARB_IDLE;
                    end
                end
            end
            default: next_st.arb = ARB_IDLE;
        endcase

        // Whole-reply counts; a push and a pop in one cycle cancel, so none is lost.
        for (int p = 0; p < NUM_DRIVES; p++) begin
            cr_in = rep_in_valid[p] && rep_in_ready[p] && (st.rx[p+1].sh == CHAR_CR);
            cr_out = rep_pop[p] && (rep_out_data[p] == CHAR_CR);
            next_st.cr_cnt[p] = st.cr_cnt[p] + 4'(cr_in) - 4'(cr_out);
        end

        // Activity pulse is stretched so an eye can see it; commands closer than
        // the pulse length merge into one longer flash.
        if (cmd_in_valid && st.rx[0].sh == CHAR_CR) begin
            next_st.led_cnt = LED_LAST;
            next_st.activity = 1'b1;
        end else if (st.led_cnt != '0) begin
            next_st.led_cnt = st.led_cnt - 1'b1;
        end else begin
            next_st.activity = 1'b0;
        end

        next_st.power = port1_powered;

        // The retained mode is taken once after reset, then only changed on request.
        if (!st.mode_loaded) begin
            next_st.mode = mode_retained;
            next_st.mode_loaded = 1'b1;
        end else if (mode_set.valid) begin
            next_st.mode = mode_set.mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            for (int c = 0; c < NUM_CHAN; c++) begin
                st.rx[c].st <= RX_IDLE;
                st.tx[c].line <= 1'b1;
            end
            st.arb <= ARB_IDLE;
            st.cmd_first <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_tx_start;
        @(posedge mclk) disable iff (!nrst || !ce)
        $rose(st.tx[0].busy) |-> !serial_out.host ##1 !serial_out.host;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit missing");

    property p_tx_stop;
        @(posedge mclk) disable iff (!nrst || !ce)
        $fell(st.tx[0].busy) |-> serial_out.host && $past(serial_out.host);
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("stop bit missing");

    property p_rx_accept;
        @(posedge mclk) disable iff (!nrst || !ce)
        st.rx[0].done && router_active && cmd_in_ready |=> cmd_out_valid;
    endproperty
    a_rx_accept: assert property (p_rx_accept) else $error("host char not taken");

    property p_addr_steer;
        @(posedge mclk) disable iff (!nrst || !ce)
        cmd_pop && st.cmd_first && cmd_is_addr |=> $onehot(st.cmd_mask) && !st.cmd_first;
    endproperty
    a_addr_steer: assert property (p_addr_steer) else $error("address not steered");

    property p_broadcast;
        @(posedge mclk) disable iff (!nrst || !ce)
        cmd_pop && st.cmd_first && !cmd_is_addr |=> st.tx[1].busy && st.tx[2].busy
            && st.tx[3].busy && st.tx[4].busy;
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast incomplete");

    property p_reply_tag;
        @(posedge mclk) disable iff (!nrst || !ce)
        st.arb == ARB_ADDR |=> st.tx[0].busy
            && st.tx[0].sh[8:1] == CHAR_ADDR_BASE + 8'($past(st.sel));
    endproperty
    a_reply_tag: assert property (p_reply_tag) else $error("reply tag wrong");

    property p_activity;
        @(posedge mclk) disable iff (!nrst || !ce)
        cmd_in_valid && st.rx[0].sh == CHAR_CR |=> link_activity_indicator [*8];
    endproperty
    a_activity: assert property (p_activity) else $error("activity not pulsed");

    property p_power;
        @(posedge mclk) disable iff (!nrst || !ce)
        1'b1 |=> power_indicator == $past(port1_powered);
    endproperty
    a_power: assert property (p_power) else $error("power lamp wrong");

    property p_mode_hold;
        @(posedge mclk) disable iff (!nrst || !ce)
        st.mode_loaded && !mode_set.valid |=> $stable(power_up_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

    property p_no_interleave;
        @(posedge mclk) disable iff (!nrst || !ce)
        (rep_pop != '0) |-> $onehot(rep_pop) && rep_pop[st.sel] && st.arb == ARB_BODY;
    endproperty
    a_no_interleave: assert property (p_no_interleave) else $error("replies mixed");

    c_broadcast: cover property (@(posedge mclk) cmd_pop && st.cmd_first && !cmd_is_addr);
    c_addressed: cover property (@(posedge mclk) cmd_pop && st.cmd_first && cmd_is_addr);
    c_reply_done: cover property (@(posedge mclk) st.arb == ARB_BODY ##1 st.arb == ARB_IDLE);
    c_overflow: cover property (@(posedge mclk) (rep_in_valid & ~rep_in_ready) != '0);

endmodule : serial_command_router_hub

// >>> sim/serial_end.sv
`timescale 1ns/1ps

// Behavioural serial endpoint standing in for the host or for one drive.
module serial_end #(
    parameter int BT = 16
) (
    input wire logic mclk,
    input wire logic rx,
    output logic tx,
    output logic got,
    output logic [7:0] got_byte
);
    // The line idles high between frames, as an unused serial pin would.
    initial begin
        tx = 1'b1;
        got = 1'b0;
        got_byte = 8'h00;
    end

    // Frames go out LSB first with one stop bit, and nothing waits for a handshake.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk);
            tx = f[i];
            repeat (BT - 1) @(negedge mclk);
        end
    endtask : send

    // Mid-bit sampling; a frame with a low stop bit is dropped, not guessed at.
    initial begin : rx_loop
        logic [7:0] d;
        forever begin
            @(negedge rx);
            repeat (BT / 2) @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BT) @(posedge mclk);
                d[i] = rx;
            end
            repeat (BT) @(posedge mclk);
            if (rx === 1'b1) begin
                got_byte = d;
                got = 1'b1;
                @(negedge mclk);
                got = 1'b0;
            end
        end
    end
endmodule : serial_end

// >>> sim/tb_serial_command_router_hub.sv
`timescale 1ns/1ps

module tb_serial_command_router_hub;
    import hub_pkg::*;
    localparam int BT = 16;
    localparam int LT = 40;
    logic mclk, nrst, ce, port1_powered;
    logic [7:0] c;
    logic [7:0] rb [4][8];
    logic [3:0][7:0] rc;
    power_mode_t mode_retained, power_up_mode;
    mode_set_t mode_set;
    serial_lines_t serial_in, serial_out;
    logic router_active, link_activity_indicator, power_indicator;
    wire [4:0] tx_line, got, rx_line;
    wire [4:0][7:0] got_byte;
    logic [7:0] rq [5][$];
    logic [7:0] eq [5][$];
    int errors, cmp_count, cycles, pulses;

    ////////////////////////////////////////////////////////////
    // Index 4 is the host, 0..3 are drive ports 1..4, matching the struct packing.
    assign serial_in = tx_line;
    assign rx_line = serial_out;
    serial_command_router_hub #(.BIT_TIME(BT), .LED_TIME(LT)) dut (.mclk(mclk), .nrst(nrst),
        .ce(ce), .serial_in(serial_in), .serial_out(serial_out), .port1_powered(port1_powered),
        .mode_retained(mode_retained), .mode_set(mode_set), .power_up_mode(power_up_mode),
        .router_active(router_active), .link_activity_indicator(link_activity_indicator),
        .power_indicator(power_indicator));
    for (genvar i = 0; i < 5; i++) begin : g
        serial_end #(.BT(BT)) m (.mclk(mclk), .rx(rx_line[i]), .tx(tx_line[i]), .got(got[i]),
            .got_byte(got_byte[i]));
        // Every received character is queued for comparison with the bench model.
        always @(posedge got[i]) rq[i].push_back(got_byte[i]);
    end

    // Clock, lamp flash counter and hang guard.
    always #12.5 mclk = ~mclk;
    always @(posedge link_activity_indicator) pulses++;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic hs(input logic [7:0] b);
        g[4].m.send(b);
    endtask : hs

    // Waits for the expected traffic, then a spell more so stray characters show up.
    task automatic settle(input string name);
        int want, have;
        for (int k = 0; k < 8000; k++) begin
            want = 0;
            have = 0;
            for (int i = 0; i < 5; i++) begin
                want += eq[i].size();
                have += rq[i].size();
            end
            if (have >= want) break;
            @(posedge mclk);
        end
        repeat (12 * BT) @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            chk("char count", 8'(rq[i].size()), 8'(eq[i].size()));
            while (eq[i].size() > 0 && rq[i].size() > 0) chk("char", rq[i].pop_front(), eq[i].pop_front());
            rq[i].delete();
            eq[i].delete();
        end
        $display("test %s done", name);
    endtask : settle

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        port1_powered = 1'b0;
        mode_retained = MODE_ROUTER;
        mode_set = '0;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        pulses = 0;
        void'($urandom(51));
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        chk("power_up_mode", 8'(power_up_mode), 8'(MODE_ROUTER));
        chk("router_active", 8'(router_active), 8'h01);
        for (int i = 0; i < 6; i++) begin
            @(negedge mclk) port1_powered = 1'($urandom);
            @(negedge mclk) chk("power_indicator", 8'(power_indicator), 8'(port1_powered));
        end
        // With the clock enable low the lamp must keep its old state.
        @(negedge mclk) ce = 1'b0;
        port1_powered = !port1_powered;
        @(negedge mclk) chk("frozen power_indicator", 8'(power_indicator), 8'(!port1_powered));
        ce = 1'b1;
        // Addressed commands: the digit is stripped, only its port hears the rest.
        for (int p = 0; p < 4; p++) begin
            c = 8'h41 + 8'($urandom % 26);
            eq[p].push_back(c);
            eq[p].push_back(CHAR_CR);
            hs(CHAR_ADDR_BASE + 8'(p));
            hs(c);
            hs(CHAR_CR);
            settle("addressed");
        end
        // A leading 0 is no address, and a bare return is broadcast as well.
        c = 8'h41 + 8'($urandom % 26);
        for (int p = 0; p < 4; p++) eq[p] = '{8'h30, c, CHAR_CR, CHAR_CR};
        hs(8'h30);
        hs(c);
        hs(CHAR_CR);
        repeat (4 * LT) @(negedge mclk);
        hs(CHAR_CR);
        settle("broadcast");
        chk("activity flashes", 8'(pulses), 8'h06);
        // Stored-program mode must route nothing.
        @(negedge mclk) mode_set = '{valid: 1'b1, mode: MODE_PROGRAM};
        @(negedge mclk) mode_set = '0;
        chk("router_active", 8'(router_active), 8'h00);
        hs(8'h31);
        hs(CHAR_CR);
        settle("program mode");
        @(negedge mclk) mode_set = '{valid: 1'b1, mode: MODE_ROUTER};
        @(negedge mclk) mode_set = '0;
        chk("power_up_mode", 8'(power_up_mode), 8'(MODE_ROUTER));
        // A second reset clears the mode, so only a fresh capture brings routing back.
        @(negedge mclk) nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        chk("mode after reset", 8'(power_up_mode), 8'(MODE_ROUTER));
        chk("router_active after reset", 8'(router_active), 8'h01);
        // All drives answer at once; replies come back whole and tagged, port 1 first.
        for (int p = 0; p < 4; p++) begin
            rc[p] = 8'h41 + 8'($urandom % 26);
            eq[4].push_back(CHAR_ADDR_BASE + 8'(p));
            eq[4].push_back(rc[p]);
            eq[4].push_back(CHAR_CR);
        end
        fork
            begin g[0].m.send(rc[0]); g[0].m.send(CHAR_CR); end
            begin g[1].m.send(rc[1]); g[1].m.send(CHAR_CR); end
            begin g[2].m.send(rc[2]); g[2].m.send(CHAR_CR); end
            begin g[3].m.send(rc[3]); g[3].m.send(CHAR_CR); end
        join
        settle("replies");
        // Eight-character replies from all drives at once: every port fills its buffer to the
        // brim before port 1 starts to drain, and nothing may be lost.
        for (int p = 0; p < 4; p++) begin
            eq[4].push_back(CHAR_ADDR_BASE + 8'(p));
            for (int k = 0; k < 8; k++) begin
                rb[p][k] = (k == 7) ? CHAR_CR : 8'h41 + 8'($urandom % 26);
                eq[4].push_back(rb[p][k]);
            end
        end
        fork
            for (int k = 0; k < 8; k++) g[0].m.send(rb[0][k]);
            for (int k = 0; k < 8; k++) g[1].m.send(rb[1][k]);
            for (int k = 0; k < 8; k++) g[2].m.send(rb[2][k]);
            for (int k = 0; k < 8; k++) g[3].m.send(rb[3][k]);
        join
        settle("reply buffers");
        chk("host line idle", 8'(serial_out.host), 8'h01);
        chk("drive lines idle", 8'(serial_out.drive), 8'h0F);
        chk("activity flashes", 8'(pulses), 8'h06);
        final_report();
    end
endmodule : tb_serial_command_router_hub
